// [nv_dev_model.sv]
/*
 * Pin-level model of the battery-backed timekeeping SRAM: byte store,
 * cell-health flag, power-fail reset. Assumes strobes move with the host clock.
 */
`timescale 1ns/10ps
`default_nettype none
module nv_dev_model (
    input wire logic i_pf,
    input wire logic i_cell_ok,
    input wire logic [14:0] i_addr,
    input wire logic [7:0] i_dq,
    input wire logic i_dq_oe,
    input wire logic i_ce_n,
    input wire logic i_we_n,
    input wire logic i_oe_n,
    output logic [7:0] o_dq,
    output logic o_rst_oe
);
    // ------------------------------------------------------------------
    // Storage, write and read paths
    // ------------------------------------------------------------------
    logic [7:0] mem [0:32767];
    logic [7:0] last = 8'h00;
    logic wr_act = 1'b0;
    logic backup_en = 1'b0;
    logic rd_on;
    logic [7:0] rd_val;
    always @(negedge i_pf) backup_en = 1'b1;
    always @(negedge i_ce_n or negedge i_we_n)
        if (!i_ce_n && !i_we_n && !i_pf) wr_act = 1'b1;
    always @(posedge i_ce_n or posedge i_we_n) begin
        if (wr_act) begin
            // Undriven bus commits junk, not the last value
            mem[i_addr] = i_dq_oe ? i_dq : ~last;
            wr_act = 1'b0;
        end
    end
    always @(posedge i_pf) wr_act = 1'b0;
    // Inert until the first power-up has enabled the backup cell
    assign rd_on = !i_ce_n && !i_oe_n && i_we_n && !i_pf && backup_en;
    assign rd_val = (i_addr == nv_host_pkg::DAY_ADDR) ?
        {i_cell_ok, mem[i_addr][6:0]} : mem[i_addr];
    always @* begin
        if (rd_on) begin
            o_dq = rd_val;
            last = rd_val;
        end else o_dq = ~last;
    end
    assign o_rst_oe = i_pf;
endmodule // nv_dev_model
`default_nettype wire

// [nv_host_pkg.sv]
/*
 * Constants shared by the host-side controller of a byte-wide battery-backed
 * timekeeping SRAM: bus widths, the cell-health location and the timing figures.
 * Assumes a 200 MHz system clock. Timing figures are those of the 5 V part.
 */
`default_nettype none

package nv_host_pkg;
    // ------------------------------------------------------------------
    // Bus shape and special locations
    // ------------------------------------------------------------------
    localparam int ADDR_W = 15;
    localparam int DATA_W = 8;
    localparam int TMR_W = 8;
    localparam logic [14:0] DAY_ADDR = 15'h7ffc;
    localparam int CELL_BIT = 7;
    localparam logic CELL_RST = 1'b0;

    // ------------------------------------------------------------------
    // Timing, in ns as printed, then in clock cycles
    // ------------------------------------------------------------------
    localparam int CLK_MHZ = 200;
    localparam int WE_PULSE_NS = 50;
    localparam int CE_PULSE_NS = 60;
    localparam int DATA_LEAD_TIME_NS = 30;
    localparam int DATA_TRAIL_TIME_NS = 0;
    localparam int ADDR_HOLD_NS = 5;
    localparam int RECOVERY_GAP_NS = 5;
    localparam int WRITE_CYCLE_NS = 70;
    localparam int READ_CYCLE_NS = 70;
    localparam int OUTPUT_RELEASE_DELAY_NS = 25;

    // Least times round up; only a zero figure gives zero cycles
    localparam int WE_PULSE_CYC = (WE_PULSE_NS * CLK_MHZ + 999) / 1000;
    localparam int CE_PULSE_CYC = (CE_PULSE_NS * CLK_MHZ + 999) / 1000;
    localparam int DATA_LEAD_CYC = (DATA_LEAD_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam int DATA_TRAIL_CYC = (DATA_TRAIL_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam int ADDR_HOLD_CYC = (ADDR_HOLD_NS * CLK_MHZ + 999) / 1000;
    localparam int RECOVERY_GAP_CYC = (RECOVERY_GAP_NS * CLK_MHZ + 999) / 1000;
    localparam int WRITE_CYCLE_CYC = (WRITE_CYCLE_NS * CLK_MHZ + 999) / 1000;
    localparam int READ_CYCLE_CYC = (READ_CYCLE_NS * CLK_MHZ + 999) / 1000;
    localparam int RELEASE_CYC = (OUTPUT_RELEASE_DELAY_NS * CLK_MHZ + 999) / 1000;

    localparam int PULSE_A = (WE_PULSE_CYC > CE_PULSE_CYC) ? WE_PULSE_CYC : CE_PULSE_CYC;
    localparam int PULSE_CYC = (PULSE_A > DATA_LEAD_CYC) ? PULSE_A : DATA_LEAD_CYC;
    localparam int HOLD_A = (DATA_TRAIL_CYC > ADDR_HOLD_CYC) ? DATA_TRAIL_CYC : ADDR_HOLD_CYC;
    localparam int HOLD_CYC = (HOLD_A > 1) ? HOLD_A : 1;
    localparam int WC_REST = WRITE_CYCLE_CYC - PULSE_CYC - HOLD_CYC;
    localparam int WREC_A = (RECOVERY_GAP_CYC > WC_REST) ? RECOVERY_GAP_CYC : WC_REST;
    localparam int WREC_CYC = (WREC_A > 1) ? WREC_A : 1;
    localparam int RREC_A = (RECOVERY_GAP_CYC > RELEASE_CYC) ? RECOVERY_GAP_CYC : RELEASE_CYC;
    localparam int RREC_CYC = (RREC_A > 1) ? RREC_A : 1;
    localparam int READ_CYC = (READ_CYCLE_CYC > 1) ? READ_CYCLE_CYC : 1;

    // ------------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [5:0] {
        ST_IDLE = 6'b000001,
        ST_WPULSE = 6'b000010,
        ST_WHOLD = 6'b000100,
        ST_READ = 6'b001000,
        ST_RECOVER = 6'b010000,
        ST_PFAIL = 6'b100000
    } state_t;
endpackage

`default_nettype wire

// [nv_sram_host.sv]
/*
 * Host controller for a byte-wide battery-backed timekeeping SRAM. Turns one
 * request at a time into a read or write cycle on the asynchronous pins, watches
 * the open-drain power-fail reset line and tracks the backup-cell health flag.
 * Assumes the pins are synchronous to i_clk_sys and the reset line has a pull-up.
 */
// Operation
// - Host holds address stable through write
// - Strobes inactive for recovery gap between cycles
// - Output drive high during writes
// - Reset line open-drain, board pulls up
// - Host releases all lines on power down; only the data bus is released, strobes go high, address to zero
`timescale 1ns/10ps
`default_nettype none

module nv_sram_host (
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic i_clk_en,
    input wire logic i_req_valid,
    input wire logic i_req_write,
    input wire logic [14:0] i_req_addr,
    input wire logic [7:0] i_req_wdata,
    output logic o_req_ready,
    output logic o_rsp_valid,
    output logic o_rsp_aborted,
    output logic [7:0] o_rsp_rdata,
    output logic o_power_fail,
    output logic o_cell_exhausted,
    output logic [14:0] o_sram_addr,
    output logic [7:0] o_sram_dq_out,
    output logic o_sram_dq_oe,
    input wire logic [7:0] i_sram_dq_in,
    output logic o_sram_ce_n,
    output logic o_sram_we_n,
    output logic o_sram_oe_n,
    input wire logic i_sram_rst_n
);
    // ------------------------------------------------------------------
    // State and registers
    // ------------------------------------------------------------------
    nv_host_pkg::state_t state_q, state_d;
    logic ready_q, ready_d;
    logic rsp_valid_q, rsp_valid_d;
    logic rsp_aborted_q, rsp_aborted_d;
    logic [7:0] rdata_q, rdata_d;
    logic pf_q;
    logic cell_bad_q, cell_bad_d;
    logic [14:0] addr_q, addr_d;
    logic [7:0] dq_q, dq_d;
    logic dq_oe_q, dq_oe_d;
    logic ce_n_q, ce_n_d;
    logic we_n_q, we_n_d;
    logic oe_n_q, oe_n_d;

    phase_timer_if tif ();

    phase_timer u_timer (
        .i_clk_sys(i_clk_sys),
        .i_reset_n(i_reset_n),
        .i_clk_en(i_clk_en),
        .tif(tif.tmr)
    );

    // ------------------------------------------------------------------
    // Decoding
    // ------------------------------------------------------------------
    // Reset line is only ever sampled, never driven; the board pulls it up
    wire pf_now = !i_sram_rst_n;
    wire take = i_req_valid && ready_q && !pf_now;
    wire in_flight = (state_q == nv_host_pkg::ST_WPULSE) || (state_q == nv_host_pkg::ST_READ);
    wire day_read = (addr_q == nv_host_pkg::DAY_ADDR);

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        ready_d = ready_q;
        rsp_valid_d = 1'b0;
        rsp_aborted_d = rsp_aborted_q;
        rdata_d = rdata_q;
        cell_bad_d = cell_bad_q;
        addr_d = addr_q;
        dq_d = dq_q;
        dq_oe_d = dq_oe_q;
        ce_n_d = ce_n_q;
        we_n_d = we_n_q;
        oe_n_d = oe_n_q;
        tif.load = 1'b0;
        tif.count = 8'h01;
        if (pf_now && state_q != nv_host_pkg::ST_PFAIL) begin
            // Strobes rise at once so a half-done write never lands
            ce_n_d = 1'b1;
            we_n_d = 1'b1;
            oe_n_d = 1'b1;
            dq_oe_d = 1'b0;
            addr_d = 15'h0000;
            dq_d = 8'h00;
            ready_d = 1'b0;
            rsp_valid_d = in_flight || state_q == nv_host_pkg::ST_WHOLD;
            rsp_aborted_d = in_flight;
            state_d = nv_host_pkg::ST_PFAIL;
        end else begin
            unique case (state_q)
                nv_host_pkg::ST_IDLE: begin
                    if (take) begin
                        ready_d = 1'b0;
                        rsp_aborted_d = 1'b0;
                        addr_d = i_req_addr;
                        ce_n_d = 1'b0;
                        tif.load = 1'b1;
                        if (i_req_write) begin
                            // Both strobes fall together, so the start edge is shared
                            we_n_d = 1'b0;
                            oe_n_d = 1'b1;
                            dq_d = i_req_wdata;
                            dq_oe_d = 1'b1;
                            tif.count = 8'(nv_host_pkg::PULSE_CYC);
                            state_d = nv_host_pkg::ST_WPULSE;
                        end else begin
                            we_n_d = 1'b1;
                            oe_n_d = 1'b0;
                            tif.count = 8'(nv_host_pkg::READ_CYC);
                            state_d = nv_host_pkg::ST_READ;
                        end
                    end
                end
                nv_host_pkg::ST_WPULSE: begin
                    if (tif.done) begin
                        ce_n_d = 1'b1;
                        we_n_d = 1'b1;
                        tif.load = 1'b1;
                        tif.count = 8'(nv_host_pkg::HOLD_CYC);
                        state_d = nv_host_pkg::ST_WHOLD;
                    end
                end
                nv_host_pkg::ST_WHOLD: begin
                    if (tif.done) begin
                        dq_oe_d = 1'b0;
                        rsp_valid_d = 1'b1;
                        tif.load = 1'b1;
                        tif.count = 8'(nv_host_pkg::WREC_CYC);
                        state_d = nv_host_pkg::ST_RECOVER;
                    end
                end
                nv_host_pkg::ST_READ: begin
                    if (tif.done) begin
                        rdata_d = i_sram_dq_in;
                        if (day_read) begin
                            cell_bad_d = !i_sram_dq_in[nv_host_pkg::CELL_BIT];
                        end
                        ce_n_d = 1'b1;
                        oe_n_d = 1'b1;
                        rsp_valid_d = 1'b1;
                        tif.load = 1'b1;
                        // Gap also covers the device's output release delay
                        tif.count = 8'(nv_host_pkg::RREC_CYC);
                        state_d = nv_host_pkg::ST_RECOVER;
                    end
                end
                nv_host_pkg::ST_RECOVER: begin
                    if (tif.done) begin
                        ready_d = 1'b1;
                        state_d = nv_host_pkg::ST_IDLE;
                    end
                end
                nv_host_pkg::ST_PFAIL: begin
                    // Device holds its reset low until supply is nominal again
                    if (!pf_now) begin
                        tif.load = 1'b1;
                        tif.count = 8'(nv_host_pkg::WREC_CYC);
                        state_d = nv_host_pkg::ST_RECOVER;
                    end
                end
                default: begin
                    ce_n_d = 1'b1;
                    we_n_d = 1'b1;
                    oe_n_d = 1'b1;
                    dq_oe_d = 1'b0;
                    ready_d = 1'b0;
                    tif.load = 1'b1;
                    tif.count = 8'(nv_host_pkg::WREC_CYC);
                    state_d = nv_host_pkg::ST_RECOVER;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            // Start as in power fail, so a high line still leads to ready
            state_q <= nv_host_pkg::ST_PFAIL;
            ready_q <= 1'b0;
            rsp_valid_q <= 1'b0;
            rsp_aborted_q <= 1'b0;
            rdata_q <= 8'h00;
            pf_q <= 1'b0;
            cell_bad_q <= nv_host_pkg::CELL_RST;
        end else if (i_clk_en) begin
            state_q <= state_d;
            ready_q <= ready_d;
            rsp_valid_q <= rsp_valid_d;
            rsp_aborted_q <= rsp_aborted_d;
            rdata_q <= rdata_d;
            pf_q <= pf_now;
            cell_bad_q <= cell_bad_d;
        end
    end

    // Pin registers kept apart so the strobes idle high from reset
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            addr_q <= 15'h0000;
            dq_q <= 8'h00;
            dq_oe_q <= 1'b0;
            ce_n_q <= 1'b1;
            we_n_q <= 1'b1;
            oe_n_q <= 1'b1;
        end else if (i_clk_en) begin
            addr_q <= addr_d;
            dq_q <= dq_d;
            dq_oe_q <= dq_oe_d;
            ce_n_q <= ce_n_d;
            we_n_q <= we_n_d;
            oe_n_q <= oe_n_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign o_req_ready = ready_q;
    assign o_rsp_valid = rsp_valid_q;
    assign o_rsp_aborted = rsp_aborted_q;
    assign o_rsp_rdata = rdata_q;
    assign o_power_fail = pf_q;
    assign o_cell_exhausted = cell_bad_q;
    assign o_sram_addr = addr_q;
    assign o_sram_dq_out = dq_q;
    assign o_sram_dq_oe = dq_oe_q;
    assign o_sram_ce_n = ce_n_q;
    assign o_sram_we_n = we_n_q;
    assign o_sram_oe_n = oe_n_q;
endmodule // nv_sram_host

`default_nettype wire

// [nv_sram_host_asserts.sv]
/*
 * Pin-timing assertions for the host controller.
 * Assumes clock enable held high, so strobe widths count in plain cycles.
 */
`timescale 1ns/10ps
`default_nettype none
module nv_sram_host_asserts (
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic i_sram_rst_n,
    input wire logic o_req_ready,
    input wire logic o_power_fail,
    input wire logic o_rsp_valid,
    input wire logic o_rsp_aborted,
    input wire logic [14:0] o_sram_addr,
    input wire logic o_sram_dq_oe,
    input wire logic o_sram_ce_n,
    input wire logic o_sram_we_n,
    input wire logic o_sram_oe_n
);
    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_reset_n);
    logic [7:0] low_cnt_q;
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) low_cnt_q <= 8'h00;
        else low_cnt_q <= o_sram_we_n ? 8'h00 : low_cnt_q + 8'h01;
    end
    we_ce_a: assert property (!o_sram_we_n |-> !o_sram_ce_n)
        else $error("write strobe low without select");
    start_shared_a: assert property ($fell(o_sram_we_n) |-> $fell(o_sram_ce_n))
        else $error("write start edges split");
    addr_hold_a: assert property (!o_sram_ce_n && !$past(o_sram_ce_n) |-> $stable(o_sram_addr))
        else $error("address moved during cycle");
    recover_gap_a: assert property ($rose(o_sram_ce_n) |=> o_sram_ce_n)
        else $error("no recovery gap");
    oe_quiet_a: assert property (!o_sram_we_n |-> o_sram_oe_n && o_sram_dq_oe)
        else $error("output drive low in write");
    rd_mode_a: assert property (!o_sram_oe_n |-> !o_sram_ce_n && o_sram_we_n && !o_sram_dq_oe)
        else $error("bad read strobes");
    pf_block_a: assert property (!i_sram_rst_n |=> o_sram_ce_n && o_sram_we_n
        && !o_sram_dq_oe && o_sram_addr == 15'h0000)
        else $error("pins active in power fail");
    pf_flag_a: assert property (!i_sram_rst_n |=> o_power_fail && !o_req_ready)
        else $error("power fail not flagged");
    we_width_a: assert property ($rose(o_sram_we_n) && $past(i_sram_rst_n)
        |-> low_cnt_q == 8'(nv_host_pkg::PULSE_CYC))
        else $error("write pulse width wrong");
    abort_rsp_a: assert property (!i_sram_rst_n && !o_sram_we_n && low_cnt_q < 8'h0a
        |-> ##[1:2] (o_rsp_valid && o_rsp_aborted))
        else $error("write not aborted");
    cover property ($rose(o_sram_we_n));
    cover property ($rose(o_sram_oe_n));
    cover property (o_rsp_valid && o_rsp_aborted);
endmodule // nv_sram_host_asserts
bind nv_sram_host nv_sram_host_asserts nv_sram_host_asserts_i (
    .i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_sram_rst_n(i_sram_rst_n),
    .o_req_ready(o_req_ready), .o_power_fail(o_power_fail), .o_rsp_valid(o_rsp_valid),
    .o_rsp_aborted(o_rsp_aborted), .o_sram_addr(o_sram_addr), .o_sram_dq_oe(o_sram_dq_oe),
    .o_sram_ce_n(o_sram_ce_n), .o_sram_we_n(o_sram_we_n), .o_sram_oe_n(o_sram_oe_n));
`default_nettype wire

// [phase_timer.sv]
/*
 * Phase timer: loaded with N, raises done in the N-th cycle after the load.
 * Assumes N is at least one and that load wins over counting.
 */
`timescale 1ns/10ps
`default_nettype none

module phase_timer (
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic i_clk_en,
    phase_timer_if.tmr tif
);
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;

    assign cnt_d = tif.load ? tif.count : ((cnt_q != 8'h00) ? cnt_q - 8'h01 : 8'h00);
    assign tif.done = (cnt_q == 8'h01);

    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cnt_q <= 8'h00;
        end else if (i_clk_en) begin
            cnt_q <= cnt_d;
        end
    end
endmodule // phase_timer

`default_nettype wire

// [phase_timer_if.sv]
/*
 * Carrier between the sequencer and its phase timer: load strobe, length, done.
 * Assumes both ends share the system clock.
 */
`timescale 1ns/10ps
`default_nettype none

interface phase_timer_if;
    logic load;
    logic [7:0] count;
    logic done;
    modport ctl (output load, output count, input done);
    modport tmr (input load, input count, output done);
endinterface

`default_nettype wire

// [tb_top.sv]
/*
 * Self-checking bench: host controller against the device model.
 * Assumes a 200 MHz clock and a pulled-up reset line from the device.
 */
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    // ------------------------------------------------------------------
    // Harness
    // ------------------------------------------------------------------
    logic i_clk_sys = 1'b0;
    logic i_reset_n = 1'b0;
    logic i_req_valid = 1'b0;
    logic i_req_write = 1'b0;
    logic [14:0] i_req_addr = 15'h0000;
    logic [7:0] i_req_wdata = 8'h00;
    logic pf = 1'b1;
    logic cell_ok = 1'b1;
    logic clk_en = 1'b1;
    logic o_req_ready, o_rsp_valid, o_rsp_aborted, o_power_fail, o_cell_exhausted;
    logic dq_oe, ce_n, we_n, oe_n, rst_oe, sram_rst_n, ab;
    logic [7:0] o_rsp_rdata, dq_out, dq_in, rd;
    logic [14:0] sram_addr;
    int fails = 0;
    int tests_run = 0;
    assign sram_rst_n = rst_oe ? 1'b0 : 1'b1;
    always #2.5 i_clk_sys = ~i_clk_sys;
    nv_sram_host nv_sram_host_i (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
        .i_clk_en(clk_en), .i_req_valid(i_req_valid), .i_req_write(i_req_write),
        .i_req_addr(i_req_addr), .i_req_wdata(i_req_wdata), .o_req_ready(o_req_ready),
        .o_rsp_valid(o_rsp_valid), .o_rsp_aborted(o_rsp_aborted), .o_rsp_rdata(o_rsp_rdata),
        .o_power_fail(o_power_fail), .o_cell_exhausted(o_cell_exhausted),
        .o_sram_addr(sram_addr), .o_sram_dq_out(dq_out), .o_sram_dq_oe(dq_oe),
        .i_sram_dq_in(dq_in), .o_sram_ce_n(ce_n), .o_sram_we_n(we_n), .o_sram_oe_n(oe_n),
        .i_sram_rst_n(sram_rst_n));
    nv_dev_model nv_dev_model_i (.i_pf(pf), .i_cell_ok(cell_ok), .i_addr(sram_addr),
        .i_dq(dq_out), .i_dq_oe(dq_oe), .i_ce_n(ce_n), .i_we_n(we_n), .i_oe_n(oe_n),
        .o_dq(dq_in), .o_rst_oe(rst_oe));
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            fails++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    // One request; pf_at counts cycles after the take before supply drops
    task automatic req(input logic w, input logic [14:0] a, input logic [7:0] d,
        input int pf_at);
        int n;
        n = 0;
        @(negedge i_clk_sys);
        i_req_valid = 1'b1;
        i_req_write = w;
        i_req_addr = a;
        i_req_wdata = d;
        while (o_req_ready !== 1'b1 && n < 60) begin
            @(negedge i_clk_sys);
            n++;
        end
        @(negedge i_clk_sys);
        i_req_valid = 1'b0;
        n = 1;
        while (o_rsp_valid !== 1'b1 && n < 60) begin
            if (n == pf_at) pf = 1'b1;
            @(negedge i_clk_sys);
            n++;
        end
        chk("response", 8'h01, {7'h00, o_rsp_valid});
        rd = o_rsp_rdata;
        ab = o_rsp_aborted;
    endtask
    task automatic t_rw();
        logic [14:0] at [3] = '{15'h0000, 15'h7fff, 15'h1234};
        logic [7:0] dt [3] = '{8'h5a, 8'ha5, 8'h00};
        for (int i = 0; i < 3; i++) req(1'b1, at[i], dt[i], 0);
        for (int i = 0; i < 3; i++) begin
            req(1'b0, at[i], 8'h00, 0);
            chk("readback", dt[i], rd);
            chk("aborted", 8'h00, {7'h00, ab});
        end
    endtask
    // Enable low: a request must not be taken and nothing may move
    task automatic t_freeze();
        while (o_req_ready !== 1'b1) @(negedge i_clk_sys);
        clk_en = 1'b0;
        i_req_valid = 1'b1;
        i_req_write = 1'b1;
        repeat (4) @(negedge i_clk_sys);
        chk("frozen_select", 8'h01, {7'h00, ce_n});
        chk("frozen_ready", 8'h01, {7'h00, o_req_ready});
        i_req_valid = 1'b0;
        clk_en = 1'b1;
    endtask
    task automatic t_cell();
        req(1'b1, nv_host_pkg::DAY_ADDR, 8'h03, 0);
        req(1'b0, nv_host_pkg::DAY_ADDR, 8'h00, 0);
        chk("day", 8'h83, rd);
        chk("exhausted", 8'h00, {7'h00, o_cell_exhausted});
        cell_ok = 1'b0;
        req(1'b0, nv_host_pkg::DAY_ADDR, 8'h00, 0);
        chk("day", 8'h03, rd);
        chk("exhausted", 8'h01, {7'h00, o_cell_exhausted});
        cell_ok = 1'b1;
    endtask
    task automatic t_pf();
        req(1'b1, 15'h0100, 8'h11, 0);
        req(1'b1, 15'h0100, 8'h22, 4);
        chk("aborted", 8'h01, {7'h00, ab});
        repeat (3) @(negedge i_clk_sys);
        chk("power_fail", 8'h01, {7'h00, o_power_fail});
        chk("ready", 8'h00, {7'h00, o_req_ready});
        chk("select", 8'h01, {7'h00, ce_n});
        pf = 1'b0;
        req(1'b0, 15'h0100, 8'h00, 0);
        chk("kept", 8'h11, rd);
    endtask
    task automatic finish_test();
        if (fails == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (16) @(negedge i_clk_sys);
        i_reset_n = 1'b1;
        // Device holds its reset line low until the first power-up
        repeat (3) @(negedge i_clk_sys);
        pf = 1'b0;
        t_rw();
        t_freeze();
        t_cell();
        t_pf();
        finish_test();
    end
    initial begin
        #100000;
        fails++;
        finish_test();
    end
endmodule // tb_top
`default_nettype wire
